// *** src/scp_serial_port.sv ***
`timescale 1ns/1ps

// small synchronous fifo between converter and serial port
module scp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_r;
  logic [AW:0]      rp_nxt;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign out_valid = (wp_r != rp_r);
  assign out_data  = mem_r[rp_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage needs no reset, only pointers do
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule // scp_fifo

module scp_serial_port
  import scp_pkg::*;
#(
  parameter logic [3:0] VERSION_ID = 4'h5  // arbitrary value
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             serial_clock_pin,
  input  wire logic             data_pin_in,
  output logic                  data_pin_out,
  output logic                  data_pin_oe,
  input  wire logic             result_valid,
  output logic                  result_ready,
  input  wire logic [RES_W-1:0] result_data,
  output logic [2:0]            gain_select,
  output logic [2:0]            rate_select,
  output logic                  channel_source_select,
  output logic                  positive_input_select,
  output logic                  negative_input_select,
  output logic                  data_pin_pullup,
  output logic                  input_buffer_enable,
  output logic                  input_short_enable,
  output logic                  reference_halving_mode,
  output logic                  whole_chip_soft_reset,
  output logic [1:0]            active_mode
);
  logic [1:0]       rst_q;
  logic             rst_n;
  logic [1:0]       s1_r;
  logic [1:0]       s2_r;
  logic [1:0]       s3_r;
  logic [1:0]       flt_r;
  logic [1:0]       flt_nxt;
  logic             rise;
  logic             fall;
  logic             din;
  logic             fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic             pop;
  // protocol state
  scp_state_type    st_r;
  scp_state_type    st_nxt;
  logic [5:0]       cnt_r;
  logic [5:0]       cnt_nxt;
  logic [11:0]      gap_r;
  logic [11:0]      gap_nxt;
  logic [2:0]       bit_r;
  logic [2:0]       bit_nxt;
  logic [3:0]       addr_r;
  logic [3:0]       addr_nxt;
  logic             rd_r;
  logic             rd_nxt;
  logic             end_r;
  logic             end_nxt;
  logic [RES_W-1:0] sh_r;
  logic [RES_W-1:0] sh_nxt;
  logic [7:0]       wsh_r;
  logic [7:0]       wsh_nxt;
  logic             dout_r;
  logic             dout_nxt;
  logic             oe_r;
  logic             oe_nxt;
  logic             wr_now;
  logic [7:0]       wr_byte;
  logic             seq_end;
  // register state
  logic [7:0]       mux_r;
  logic [7:0]       mux_nxt;
  logic [7:0]       cr0_r;
  logic [7:0]       cr0_nxt;
  logic [7:0]       cr1_r;
  logic [7:0]       cr1_nxt;
  logic [7:0]       cr2_r;
  logic [7:0]       cr2_nxt;
  logic [7:0]       cr3_r;
  logic [7:0]       cr3_nxt;
  logic             swf_r;
  logic             swf_nxt;
  logic             porf_r;
  logic             porf_nxt;
  logic             srst_r;
  logic             srst_nxt;
  logic             cfg_ok_r;
  logic             cfg_ok_nxt;
  scp_mode_type     mode_r;
  scp_mode_type     mode_nxt;

  // register readback, used for every byte of a read access
  function automatic logic [7:0] rd_byte(input logic [3:0] a);
    unique case (a)
      REG_STATUS: rd_byte = {VERSION_ID, fifo_valid, swf_r, RSV1_VAL, porf_r};
      REG_MUX:    rd_byte = mux_r;
      REG_CR0:    rd_byte = cr0_r;
      REG_CR1:    rd_byte = cr1_r;
      REG_CR2:    rd_byte = cr2_r;
      REG_CR3:    rd_byte = cr3_r;
      default:    rd_byte = 8'h00;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // three-flop pin sampling; level accepted when stages two and three agree
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= 2'h0;
      s2_r  <= 2'h0;
      s3_r  <= 2'h0;
      flt_r <= 2'h0;
    end else begin
      s1_r  <= {data_pin_in, serial_clock_pin};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  assign rise = flt_nxt[0] && !flt_r[0];
  assign fall = !flt_nxt[0] && flt_r[0];
  assign din  = flt_nxt[1];

  scp_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // a long low serial clock closes the sequence; limits slowest host clock
  assign seq_end = (gap_r == GAP_CYC) && (cnt_r != 6'h00);

  // serial protocol: counts clocks, then frames command accesses
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    gap_nxt  = gap_r;
    bit_nxt  = bit_r;
    addr_nxt = addr_r;
    rd_nxt   = rd_r;
    end_nxt  = end_r;
    sh_nxt   = sh_r;
    wsh_nxt  = wsh_r;
    dout_nxt = dout_r;
    oe_nxt   = oe_r;
    pop      = 1'b0;
    wr_now   = 1'b0;
    wr_byte  = 8'h00;
    if (flt_r[0] || rise) begin
      gap_nxt = 12'h000;
    end else if (gap_r != GAP_CYC) begin
      gap_nxt = gap_r + 12'h001;
    end
    if (seq_end) begin
      st_nxt  = ST_COUNT;
      cnt_nxt = 6'h00;
      oe_nxt  = 1'b0;
    end else if (rise) begin
      if (cnt_r != CNT_MAX) begin
        cnt_nxt = cnt_r + 6'h01;
      end
      unique case (st_r)
        ST_COUNT: begin
          if (cnt_nxt == 6'h01) begin
            pop      = fifo_valid;
            sh_nxt   = fifo_data;
            oe_nxt   = fifo_valid;
            dout_nxt = fifo_data[RES_W-1];
          end else if (cnt_nxt <= RESULT_BITS) begin
            sh_nxt   = {sh_r[RES_W-2:0], 1'b0};
            dout_nxt = sh_r[RES_W-2];
          end else begin
            oe_nxt = 1'b0;
          end
          if (cnt_nxt > CNT_USER_MAX) begin
            st_nxt = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cnt_nxt == CNT_ADDR) begin
            st_nxt = ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cnt_nxt == CNT_RW) begin
            st_nxt = ST_RW;
          end
        end
        ST_RW: begin
          st_nxt = ST_TURN;
        end
        ST_TURN, ST_END: begin
          if (st_r == ST_END && end_r) begin
            st_nxt = ST_CLOSE;
          end else begin
            st_nxt  = ST_DATA;
            bit_nxt = 3'h0;
            if (st_r == ST_END) begin
              addr_nxt = addr_r + 4'h1;
            end
            if (rd_r) begin
              sh_nxt[7:0] = rd_byte(st_r == ST_END ? addr_r + 4'h1 : addr_r);
              dout_nxt    = sh_nxt[7];
              oe_nxt      = 1'b1;
            end
          end
        end
        ST_DATA: begin
          if (bit_r == LAST_BIT) begin
            st_nxt = ST_END;
            oe_nxt = 1'b0;
          end else begin
            bit_nxt = bit_r + 3'h1;
            if (rd_r) begin
              sh_nxt[7:0] = {sh_r[6:0], 1'b0};
              dout_nxt    = sh_r[6];
            end
          end
        end
        ST_CLOSE: begin
          st_nxt = ST_CLOSE;
        end
      endcase
      if (st_r == ST_COUNT && cnt_nxt == CNT_CMD) begin
        st_nxt = ST_WAIT;
      end
    end else if (fall) begin
      unique case (st_r)
        ST_ADDR: addr_nxt = {addr_r[2:0], din};
        ST_RW:   rd_nxt   = din;
        ST_DATA: begin
          if (!rd_r) begin
            wsh_nxt = {wsh_r[6:0], din};
            if (bit_r == LAST_BIT) begin
              wr_now  = 1'b1;
              wr_byte = wsh_nxt;
            end
          end
        end
        ST_END:  end_nxt  = din;
        default: begin
        end
      endcase
    end else if (st_r == ST_COUNT && cnt_r == 6'h00) begin
      // low data pin between sequences tells the host a result waits
      oe_nxt   = fifo_valid;
      dout_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= ST_COUNT;
      cnt_r  <= 6'h00;
      gap_r  <= 12'h000;
      bit_r  <= 3'h0;
      addr_r <= 4'h0;
      rd_r   <= 1'b0;
      end_r  <= 1'b0;
      sh_r   <= '0;
      wsh_r  <= 8'h00;
      dout_r <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      gap_r  <= gap_nxt;
      bit_r  <= bit_nxt;
      addr_r <= addr_nxt;
      rd_r   <= rd_nxt;
      end_r  <= end_nxt;
      sh_r   <= sh_nxt;
      wsh_r  <= wsh_nxt;
      dout_r <= dout_nxt;
      oe_r   <= oe_nxt;
    end
  end

  // register file, mode selection and soft reset
  always_comb begin
    mux_nxt    = mux_r;
    cr0_nxt    = cr0_r;
    cr1_nxt    = cr1_r;
    cr2_nxt    = cr2_r;
    cr3_nxt    = cr3_r;
    swf_nxt    = swf_r;
    porf_nxt   = porf_r;
    srst_nxt   = 1'b0;
    cfg_ok_nxt = cfg_ok_r;
    mode_nxt   = mode_r;
    if (wr_now) begin
      unique case (addr_r)
        REG_STATUS: begin
          // write-one clears; soft reset is never written in the same cycle
          if (wr_byte[BIT_SWF]) swf_nxt = 1'b0;
          if (wr_byte[BIT_PORF]) porf_nxt = 1'b0;
        end
        REG_MUX: mux_nxt = wr_byte & MUX_MASK;
        REG_CR0: cr0_nxt = wr_byte & CR0_MASK;
        REG_CR1: cr1_nxt = wr_byte & CR1_MASK;
        REG_CR2: cr2_nxt = wr_byte & CR2_MASK;
        REG_CR3: cr3_nxt = wr_byte & CR3_MASK;
        REG_RESET: srst_nxt = wr_byte[BIT_SWRST];
        default: begin
        end
      endcase
      if (addr_r != REG_STATUS && addr_r != REG_RESET) begin
        cfg_ok_nxt = 1'b1;
      end
    end
    if (seq_end && st_r == ST_COUNT) begin
      if (cnt_r == CNT_SLOW) mode_nxt = MODE_SLOW;
      if (cnt_r == CNT_SUPPLY) mode_nxt = MODE_SUPPLY;
      if (cnt_r == CNT_FAST) mode_nxt = MODE_FAST;
      if (cnt_r >= CNT_USER_MIN && cnt_r <= CNT_USER_MAX && cfg_ok_r) begin
        mode_nxt = MODE_USER;
      end
    end
    if (srst_r) begin
      // whole-chip reset: settings back to defaults, flag left set
      mux_nxt    = MUX_RST;
      cr0_nxt    = CR0_RST;
      cr1_nxt    = CR1_RST;
      cr2_nxt    = CR2_RST;
      cr3_nxt    = CR3_RST;
      cfg_ok_nxt = 1'b0;
      mode_nxt   = MODE_SLOW;
      swf_nxt    = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_r    <= MUX_RST;
      cr0_r    <= CR0_RST;
      cr1_r    <= CR1_RST;
      cr2_r    <= CR2_RST;
      cr3_r    <= CR3_RST;
      swf_r    <= 1'b0;
      porf_r   <= 1'b1;
      srst_r   <= 1'b0;
      cfg_ok_r <= 1'b0;
      mode_r   <= MODE_SLOW;
    end else begin
      mux_r    <= mux_nxt;
      cr0_r    <= cr0_nxt;
      cr1_r    <= cr1_nxt;
      cr2_r    <= cr2_nxt;
      cr3_r    <= cr3_nxt;
      swf_r    <= swf_nxt;
      porf_r   <= porf_nxt;
      srst_r   <= srst_nxt;
      cfg_ok_r <= cfg_ok_nxt;
      mode_r   <= mode_nxt;
    end
  end

  // analog controls; slow and fast modes override the stored user settings, supply mode keeps the stored gain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_select           <= GAIN_128;
      rate_select           <= RATE_10;
      channel_source_select <= 1'b0;
    end else begin
      unique case (mode_r)
        MODE_SLOW: begin
          gain_select           <= GAIN_128;
          rate_select           <= RATE_10;
          channel_source_select <= 1'b0;
        end
        MODE_FAST: begin
          gain_select           <= GAIN_128;
          rate_select           <= RATE_40;
          channel_source_select <= 1'b0;
        end
        MODE_SUPPLY: begin
          gain_select           <= cr1_r[GAIN_LSB +: 3];
          rate_select           <= RATE_40;
          channel_source_select <= 1'b1;
        end
        MODE_USER: begin
          gain_select           <= cr1_r[GAIN_LSB +: 3];
          rate_select           <= cr1_r[RATE_LSB +: 3];
          channel_source_select <= mux_r[BIT_CH_SEL];
        end
      endcase
    end
  end

  assign positive_input_select  = mux_r[BIT_PMUX];
  assign negative_input_select  = mux_r[BIT_NMUX];
  assign data_pin_pullup        = cr0_r[BIT_PULLUP];
  assign input_buffer_enable    = cr0_r[BIT_BUFEN];
  assign input_short_enable     = cr2_r[BIT_SHORT];
  assign reference_halving_mode = cr3_r[BIT_VREF];
  assign whole_chip_soft_reset  = srst_r;
  assign active_mode            = mode_r;
  assign data_pin_out           = dout_r;
  assign data_pin_oe            = oe_r;
endmodule // scp_serial_port

// *** src/scp_pkg.sv ***
package scp_pkg;
  // timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SEQ_GAP_NS    = 20000;
  localparam int          GAP_W         = 12;
  localparam logic [11:0] GAP_CYC       =
    12'((SEQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // register offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MUX    = 4'h1;
  localparam logic [3:0] REG_CR0    = 4'h2;
  localparam logic [3:0] REG_CR1    = 4'h3;
  localparam logic [3:0] REG_CR2    = 4'h4;
  localparam logic [3:0] REG_CR3    = 4'h5;
  localparam logic [3:0] REG_RESET  = 4'hf;
  // reset values and writable masks
  localparam logic [7:0] MUX_RST  = 8'h10;
  localparam logic [7:0] CR0_RST  = 8'h40;
  localparam logic [7:0] CR1_RST  = 8'h70;
  localparam logic [7:0] CR2_RST  = 8'h30;
  localparam logic [7:0] CR3_RST  = 8'h00;
  localparam logic [7:0] MUX_MASK = 8'h91;
  localparam logic [7:0] CR0_MASK = 8'h76;
  localparam logic [7:0] CR1_MASK = 8'h77;
  localparam logic [7:0] CR2_MASK = 8'h79;
  localparam logic [7:0] CR3_MASK = 8'h02;
  // field positions
  localparam int BIT_CH_SEL = 7;
  localparam int BIT_PMUX   = 4;
  localparam int BIT_NMUX   = 0;
  localparam int BIT_PULLUP = 2;
  localparam int BIT_BUFEN  = 1;
  localparam int GAIN_LSB   = 4;
  localparam int RATE_LSB   = 0;
  localparam int BIT_SHORT  = 0;
  localparam int BIT_VREF   = 1;
  localparam int BIT_SWRST  = 1;
  localparam int BIT_SWF    = 2;
  localparam int BIT_PORF   = 0;
  localparam logic RSV1_VAL = 1'b1;
  // fixed-mode settings
  localparam logic [2:0] GAIN_128 = 3'h7;
  localparam logic [2:0] RATE_10  = 3'h0;
  localparam logic [2:0] RATE_40  = 3'h2;
  // serial clock numbers
  localparam logic [5:0] CNT_SLOW     = 6'h19;
  localparam logic [5:0] CNT_SUPPLY   = 6'h1a;
  localparam logic [5:0] CNT_FAST     = 6'h1b;
  localparam logic [5:0] CNT_USER_MIN = 6'h1c;
  localparam logic [5:0] CNT_USER_MAX = 6'h20;
  localparam logic [5:0] CNT_CMD      = 6'h23;
  localparam logic [5:0] CNT_ADDR     = 6'h26;
  localparam logic [5:0] CNT_RW       = 6'h2a;
  localparam logic [5:0] CNT_MAX      = 6'h3f;
  localparam logic [5:0] RESULT_BITS  = 6'h18;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam int         RES_W        = 24;
  localparam int         FIFO_DEPTH   = 16;

  typedef enum logic [1:0] {
    MODE_SLOW   = 2'b00,
    MODE_FAST   = 2'b01,
    MODE_SUPPLY = 2'b10,
    MODE_USER   = 2'b11
  } scp_mode_type;

  typedef enum logic [2:0] {
    ST_COUNT = 3'b000,
    ST_WAIT  = 3'b001,
    ST_ADDR  = 3'b010,
    ST_RW    = 3'b011,
    ST_TURN  = 3'b100,
    ST_DATA  = 3'b101,
    ST_END   = 3'b110,
    ST_CLOSE = 3'b111
  } scp_state_type;
endpackage

// *** sim/scp_serial_port_monitor.sv ***
`timescale 1ns/1ps
module scp_serial_port_monitor
  import scp_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       serial_clock_pin,
  input wire logic       data_pin_oe,
  input wire logic       result_valid,
  input wire logic       result_ready,
  input wire logic [2:0] gain_select,
  input wire logic [2:0] rate_select,
  input wire logic       channel_source_select,
  input wire logic       positive_input_select,
  input wire logic       negative_input_select,
  input wire logic       data_pin_pullup,
  input wire logic       whole_chip_soft_reset,
  input wire logic [1:0] active_mode
);
  logic [2:0]  sck_r;
  logic [11:0] low_r;
  logic [6:0]  cnt_r;
  // three flops like the port, so our clock count lines up with its own
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_r <= 3'h0;
      low_r <= 12'h000;
      cnt_r <= 7'h00;
    end else begin
      sck_r <= {sck_r[1:0], serial_clock_pin};
      if (sck_r[2]) low_r <= 12'h000;
      else if (low_r != 12'hfff) low_r <= low_r + 12'h001;
      if (sck_r[1] && !sck_r[2]) cnt_r <= (low_r > 12'h76c) ? 7'h01 : cnt_r + 7'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence pulse_s;
    whole_chip_soft_reset ##1 !whole_chip_soft_reset;
  endsequence
  sequence home_s;
    positive_input_select && !negative_input_select && !data_pin_pullup;
  endsequence

  slow_gain_a: assert property (
    (active_mode == MODE_SLOW)[*3] |-> gain_select == GAIN_128 && rate_select == RATE_10
    && !channel_source_select) else $error("slow mode settings wrong");
  fast_gain_a: assert property (
    (active_mode == MODE_FAST)[*3] |-> gain_select == GAIN_128 && rate_select == RATE_40
    && !channel_source_select) else $error("fast mode settings wrong");
  supply_rate_a: assert property (
    (active_mode == MODE_SUPPLY)[*3] |-> rate_select == RATE_40 && channel_source_select)
    else $error("supply mode settings wrong");
  soft_reset_a: assert property (
    whole_chip_soft_reset |-> pulse_s ##[0:4] home_s) else $error("soft reset wrong");
  mode_count_a: assert property (
    $changed(active_mode) && low_r > 12'h7c6 |->
    cnt_r == 7'h19 && active_mode == MODE_SLOW || cnt_r == 7'h1a && active_mode == MODE_SUPPLY
    || cnt_r == 7'h1b && active_mode == MODE_FAST
    || cnt_r inside {[7'h1c:7'h20]} && active_mode == MODE_USER)
    else $error("mode change does not match clock count");
  host_slot_a: assert property (
    cnt_r inside {[7'h24:7'h2b]} |-> !data_pin_oe) else $error("device drives header");
  end_bit_a: assert property (
    $rose(cnt_r == 7'h34) |-> ##6 !data_pin_oe) else $error("device holds end bit");
  fifo_fill_a: assert property (
    $fell(result_ready) |-> $past(result_valid)) else $error("buffer full without push");
endmodule // scp_serial_port_monitor

bind scp_serial_port scp_serial_port_monitor u_mon (
  .clk(clk), .arst_n(arst_n), .serial_clock_pin(serial_clock_pin),
  .data_pin_oe(data_pin_oe), .result_valid(result_valid), .result_ready(result_ready),
  .gain_select(gain_select), .rate_select(rate_select),
  .channel_source_select(channel_source_select),
  .positive_input_select(positive_input_select),
  .negative_input_select(negative_input_select), .data_pin_pullup(data_pin_pullup),
  .whole_chip_soft_reset(whole_chip_soft_reset), .active_mode(active_mode));

// *** sim/scp_host_model.sv ***
`timescale 1ns/1ps
// host end of the link; the clock stands low outside frames
module scp_host_model (
  output logic      serial_clock_pin,
  output logic      host_oe,
  output logic      host_val,
  input  wire logic data_level
);
  initial begin
    serial_clock_pin = 1'b0;
    host_oe = 1'b0;
    host_val = 1'b0;
  end

  // one clock of 125 ns; drive late so the device lets go first
  task automatic pulse(input logic own, input logic val, output logic seen);
    serial_clock_pin = 1'b1;
    #55;
    host_oe = own;
    host_val = val;
    #7.5;
    serial_clock_pin = 1'b0;
    #32.5;
    host_oe = 1'b0;
    #30;
    seen = data_level;
  endtask

  // pin released; first 24 bits collected msb first
  task automatic clocks(input int n, output logic [23:0] res);
    logic s;
    for (int k = 1; k <= n; k++) begin
      pulse(1'b0, 1'b0, s);
      if (k <= 24) res = {res[22:0], s};
    end
  endtask

  // sequence ends only after a long low clock
  task automatic gap();
    #21500;
  endtask

  task automatic cmd(input logic [3:0] a, input logic rd, input int n,
                     input logic [7:0] wd [8], output logic [7:0] rb [8]);
    logic s;
    logic [7:0] b;
    for (int k = 1; k <= 37; k++) pulse(1'b0, 1'b0, s);
    for (int k = 3; k >= 0; k--) pulse(1'b1, a[k], s);
    pulse(1'b1, rd, s);
    pulse(1'b0, 1'b0, s);
    for (int j = 0; j < n; j++) begin
      for (int k = 7; k >= 0; k--) begin
        pulse(!rd, wd[j][k], s);
        b[k] = s;
      end
      rb[j] = b;
      pulse(1'b1, j == n - 1, s);
    end
    pulse(1'b0, 1'b0, s);
  endtask
endmodule // scp_host_model

// *** sim/test_adc_serial_command_port.sv ***
`timescale 1ns/1ps
module test_adc_serial_command_port;
  import scp_pkg::*;
  logic             clk = 1'b0;
  logic             arst_n = 1'b0;
  logic             serial_clock_pin, host_oe, host_val, data_pin_in, float_r = 1'b0;
  logic             data_pin_out, data_pin_oe, result_valid = 1'b0, result_ready;
  logic [RES_W-1:0] result_data = 24'h000000;
  logic [2:0]       gain_select, rate_select;
  logic             channel_source_select, positive_input_select, negative_input_select;
  logic             data_pin_pullup, input_buffer_enable, input_short_enable;
  logic             reference_halving_mode, whole_chip_soft_reset;
  logic [1:0]       active_mode;
  logic [23:0]      res;
  logic [7:0]       wd [8], rb [8];
  int               n_errors = 0, check_count = 0, cycles = 0, n_pulse = 0;
  // address, value written (internal bits as required), value read back
  logic [3:0] row_a [6] = '{REG_MUX, REG_CR0, REG_CR1, REG_CR2, REG_CR3, 4'h7};
  logic [7:0] row_w [6] = '{8'hff, 8'h46, 8'hb5, 8'h31, 8'hff, 8'haa};
  logic [7:0] row_e [6] = '{8'h91, 8'h46, 8'h35, 8'h31, 8'h02, 8'h00};
  // clock count, then {mode, gain, rate, channel}
  int         m_n [6] = '{29, 27, 26, 25, 30, 34};
  logic [8:0] m_e [6] = '{9'h1bb, 9'h0f4, 9'h135, 9'h070, 9'h1bb, 9'h1bb};
  wire  [5:0] pins = {positive_input_select, negative_input_select, data_pin_pullup,
                      input_buffer_enable, input_short_enable, reference_halving_mode};

  always #5 clk = ~clk;
  // released line toggles each cycle while the pull-up is off, so no stale value is read as data
  assign data_pin_in = host_oe ? host_val : data_pin_oe ? data_pin_out : data_pin_pullup | float_r;
  always @(posedge clk) begin
    float_r <= ~float_r;
    cycles <= cycles + 1;
    if (whole_chip_soft_reset === 1'b1) n_pulse <= n_pulse + 1;
    // a clean run needs about 93000 cycles
    if (cycles == 99000) begin
      n_errors++;
      end_of_test();
    end
  end

  scp_serial_port u_dut (
    .clk(clk), .arst_n(arst_n), .serial_clock_pin(serial_clock_pin),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .gain_select(gain_select), .rate_select(rate_select),
    .channel_source_select(channel_source_select),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .data_pin_pullup(data_pin_pullup),
    .input_buffer_enable(input_buffer_enable), .input_short_enable(input_short_enable),
    .reference_halving_mode(reference_halving_mode),
    .whole_chip_soft_reset(whole_chip_soft_reset), .active_mode(active_mode));
  scp_host_model u_host (.serial_clock_pin(serial_clock_pin), .host_oe(host_oe),
    .host_val(host_val), .data_level(data_pin_in));

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    wd[0] = v;
    u_host.cmd(a, 1'b0, 1, wd, rb);
    u_host.gap();
  endtask
  task automatic rd(input logic [3:0] a, input int n);
    u_host.cmd(a, 1'b1, n, wd, rb);
    u_host.gap();
  endtask
  function automatic logic [23:0] val(input int i);
    return {4'(i), 4'(~i), 16'h3c5a};
  endfunction

  initial begin
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (10) @(posedge clk);
    check("reset", {active_mode, gain_select, rate_select, pins}, 14'h0e20);
    for (int i = 0; i < 6; i++) wr(row_a[i], row_w[i]);
    rd(REG_MUX, 7);
    for (int i = 0; i < 6; i++) check("reg", rb[row_a[i] - 4'h1], row_e[i]);
    check("pins", pins, 6'h3f);
    for (int i = 0; i < 6; i++) begin
      // results taken right after a change are never used
      u_host.clocks(m_n[i], res);
      u_host.gap();
      check("mode", {active_mode, gain_select, rate_select, channel_source_select}, m_e[i]);
    end
    wr(REG_RESET, 8'h02);
    check("pulse", n_pulse, 1);
    rd(REG_STATUS, 6);
    check("soft", {rb[0], rb[1], rb[2], rb[3], rb[4], rb[5]}, 48'h571040703000);
    wr(REG_STATUS, 8'h01);
    rd(REG_STATUS, 1);
    check("status", rb[0], 8'h56);
    wr(REG_STATUS, 8'h04);
    rd(REG_STATUS, 1);
    check("status", rb[0], 8'h52);
    // fill the buffer until it refuses
    @(posedge clk);
    #1 result_valid = 1'b1;
    for (int i = 0; i <= 16; i++) begin
      result_data = val(i);
      check("ready", result_ready, i < 16);
      @(posedge clk);
      #1;
    end
    result_valid = 1'b0;
    check("idle", {data_pin_oe, data_pin_out}, 2'b10);
    // the command's first clock takes the oldest result off the buffer
    rd(REG_STATUS, 1);
    check("ready flag", rb[0], 8'h5a);
    for (int i = 1; i < 16; i++) begin
      u_host.clocks(25, res);
      u_host.gap();
      check("result", res, val(i));
    end
    check("drained", {result_ready, data_pin_oe}, 2'b10);
    end_of_test();
  end
endmodule // test_adc_serial_command_port
